// *** include/ext_dp_defines.svh ***
// timing counts, flag positions and reset values of the far datapath
// assumes nothing; included by far_alu, the datapath and the bench, not by the package
`ifndef EXT_DP_DEFINES_SVH
`define EXT_DP_DEFINES_SVH
// ----------------------------------------
// instruction lengths in core_clk cycles
// ----------------------------------------
`define PLAIN_CYCLES 2
`define SKIP_CYCLES  3
// ----------------------------------------
// status flag bit positions
// ----------------------------------------
`define F_C  0
`define F_AC 1
`define F_Z  2
`define F_OV 3
`define F_SC 4
`define F_CZ 5
// ----------------------------------------
// values
// ----------------------------------------
`define ACC_RST   8'h00
`define FLAGS_RST 8'h00
`define ALL_ONES  8'hFF
`define ONE_BYTE  8'h01
`endif

// *** include/ext_dp_pkg.sv ***
// types shared by the far datapath and its alu
// assumes nothing; uses no macros from ext_dp_defines.svh
package ext_dp_pkg;
  typedef logic [7:0] byte_t;
  // ----------------------------------------
  // far instruction selector
  // ----------------------------------------
  typedef enum logic [4:0] {
    far_move_to_acc_op, far_move_op, far_or_to_acc_op, far_or_to_mem_op,
    far_rotate_left_op, far_rotate_left_to_acc_op,
    far_rotate_left_thru_carry_op, far_rotate_left_thru_carry_to_acc_op,
    far_rotate_right_op, far_rotate_right_to_acc_op,
    far_rotate_right_thru_carry_op, far_rotate_right_thru_carry_to_acc_op,
    far_subtract_borrow_op, far_subtract_borrow_to_mem_op,
    far_subtract_op, far_subtract_to_mem_op,
    far_dec_skip_zero_op, far_dec_skip_zero_to_acc_op,
    far_inc_skip_zero_op, far_inc_skip_zero_to_acc_op,
    far_set_ones_op, far_set_bit_op, far_skip_bit_nonzero_op,
    far_skip_nonzero_op, far_nibble_exchange_op
  } far_op_e;
endpackage

// *** include/alu_if.sv ***
// operands and results passed between datapath and alu
// assumes ext_dp_pkg is compiled first
`timescale 1ns/10ps
interface alu_if;
  import ext_dp_pkg::*;
  far_op_e     op;
  byte_t       accIn;
  byte_t       memIn;
  logic [2:0]  bitSel;
  byte_t       flagsIn;
  byte_t       res;
  byte_t       flagsOut;
  logic        toAcc;
  logic        toMem;
  logic        skip;
  modport core (output op, accIn, memIn, bitSel, flagsIn,
                input res, flagsOut, toAcc, toMem, skip);
  modport alu  (input op, accIn, memIn, bitSel, flagsIn,
                output res, flagsOut, toAcc, toMem, skip);
endinterface

// *** hdl/far_alu.sv ***
// combinational result, flag and skip logic for one far instruction
// assumes the caller registers everything it drives out
`timescale 1ns/10ps
`include "ext_dp_defines.svh"
module far_alu (
  alu_if.alu bus
);
  import ext_dp_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // a - b - !cin as a + ~b + cin; returns {nibble carry, carry, result}
  function automatic logic [9:0] sub_step(input byte_t a, input byte_t b,
                                          input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    return {lo[4], full};
  endfunction

  logic [9:0] diff;
  logic       ov;
  byte_t      a;
  byte_t      m;
  byte_t      f;

  assign a = bus.accIn;
  assign m = bus.memIn;
  assign f = bus.flagsIn;

  // ----------------------------------------
  // per-instruction decode
  // ----------------------------------------
  always_comb begin
    diff = sub_step(a, m, (bus.op == far_subtract_borrow_op ||
                           bus.op == far_subtract_borrow_to_mem_op) ? f[`F_C] : 1'b1);
    ov = (a[7] != m[7]) && (diff[7] != a[7]);
    bus.res = m;
    bus.flagsOut = f;
    bus.toAcc = 1'b0;
    bus.toMem = 1'b0;
    bus.skip = 1'b0;
    case (bus.op)
      far_move_to_acc_op: bus.toAcc = 1'b1;
      far_move_op: begin
        bus.res = a;
        bus.toMem = 1'b1;
      end
      far_or_to_acc_op, far_or_to_mem_op: begin
        bus.res = a | m;
        bus.flagsOut[`F_Z] = ((a | m) == 8'h00);
        bus.toAcc = (bus.op == far_or_to_acc_op);
        bus.toMem = (bus.op == far_or_to_mem_op);
      end
      far_rotate_left_op, far_rotate_left_to_acc_op: begin
        bus.res = {m[6:0], m[7]};
        bus.toAcc = (bus.op == far_rotate_left_to_acc_op);
        bus.toMem = !bus.toAcc;
      end
      far_rotate_left_thru_carry_op, far_rotate_left_thru_carry_to_acc_op: begin
        bus.res = {m[6:0], f[`F_C]};
        bus.flagsOut[`F_C] = m[7];
        bus.toAcc = (bus.op == far_rotate_left_thru_carry_to_acc_op);
        bus.toMem = !bus.toAcc;
      end
      far_rotate_right_op, far_rotate_right_to_acc_op: begin
        bus.res = {m[0], m[7:1]};
        bus.toAcc = (bus.op == far_rotate_right_to_acc_op);
        bus.toMem = !bus.toAcc;
      end
      far_rotate_right_thru_carry_op, far_rotate_right_thru_carry_to_acc_op: begin
        bus.res = {f[`F_C], m[7:1]};
        bus.flagsOut[`F_C] = m[0];
        bus.toAcc = (bus.op == far_rotate_right_thru_carry_to_acc_op);
        bus.toMem = !bus.toAcc;
      end
      far_subtract_borrow_op, far_subtract_borrow_to_mem_op,
      far_subtract_op, far_subtract_to_mem_op: begin
        bus.res = diff[7:0];
        bus.flagsOut[`F_C] = diff[8];
        bus.flagsOut[`F_AC] = diff[9];
        bus.flagsOut[`F_Z] = (diff[7:0] == 8'h00);
        bus.flagsOut[`F_OV] = ov;
        bus.flagsOut[`F_SC] = diff[7] ^ ov;
        // borrow chains keep a running all-zero over the bytes
        bus.flagsOut[`F_CZ] = (diff[7:0] == 8'h00) &&
          (f[`F_CZ] || bus.op == far_subtract_op || bus.op == far_subtract_to_mem_op);
        bus.toMem = (bus.op == far_subtract_borrow_to_mem_op ||
                     bus.op == far_subtract_to_mem_op);
        bus.toAcc = !bus.toMem;
      end
      far_dec_skip_zero_op, far_dec_skip_zero_to_acc_op: begin
        bus.res = m - 8'h01;
        bus.skip = (m == `ONE_BYTE);
        bus.toAcc = (bus.op == far_dec_skip_zero_to_acc_op);
        bus.toMem = !bus.toAcc;
      end
      far_inc_skip_zero_op, far_inc_skip_zero_to_acc_op: begin
        bus.res = m + 8'h01;
        bus.skip = (m == `ALL_ONES);
        bus.toAcc = (bus.op == far_inc_skip_zero_to_acc_op);
        bus.toMem = !bus.toAcc;
      end
      far_set_ones_op: begin
        bus.res = `ALL_ONES;
        bus.toMem = 1'b1;
      end
      far_set_bit_op: begin
        bus.res = m | (`ONE_BYTE << bus.bitSel);
        bus.toMem = 1'b1;
      end
      far_skip_bit_nonzero_op: bus.skip = m[bus.bitSel];
      far_skip_nonzero_op: begin
        bus.toMem = 1'b1;
        bus.skip = (m != 8'h00);
      end
      far_nibble_exchange_op: begin
        bus.res = {m[3:0], m[7:4]};
        bus.toMem = 1'b1;
      end
      default: bus.skip = 1'b0;
    endcase
  end
endmodule

// *** hdl/extended_instruction_datapath.sv ***
// far-addressed instruction datapath: accumulator, status and data memory
// assumes a sequencer on core_clk issues one instruction at a time
//
// How it works
// - memory is reached by full address, independent of any bank select
// - move to memory copies accumulator into memory, flags untouched
// - OR of accumulator and memory goes to acc or memory; only Z changes
// - rotate left moves each bit up, bit 7 into bit 0, no flags
// - rotate right moves each bit down, bit 0 into bit 7, no flags
// - rotate left through carry: bit 7 to C, old C to bit 0
// - rotate right through carry: bit 0 to C, old C to bit 7
// - accumulator rotate variants write acc and leave memory alone
// - subtract with borrow is acc minus mem minus not C, six flags
// - subtract is acc minus mem, same six flags
// - after subtraction C is 0 for negative, 1 for zero or positive
// - decrement memory, write back, skip next when zero, no flags
// - increment memory, write back, skip next when zero, no flags
// - accumulator variants write acc, keep memory, skip on acc zero
// - skip takes three cycles with a dummy slot; else carry on
// - byte set writes FFH to memory, no flags
// - bit set raises only the chosen bit, no flags
// - bit test skips next when the chosen bit is one
// - byte test writes the byte back, skips next when nonzero
// - nibble exchange swaps memory halves in place
// - bits 3..0 trade with bits 7..4, flags untouched
`timescale 1ns/10ps
`include "ext_dp_defines.svh"
module extended_instruction_datapath #(
  parameter int ADDR_W = 9
) (
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  input  wire logic               start,
  input  wire ext_dp_pkg::far_op_e opcode,
  input  wire logic [ADDR_W-1:0]  memAddr,
  input  wire logic [2:0]         bitSel,
  input  wire logic               loadAccEn,
  input  wire logic [7:0]         loadAccData,
  input  wire logic               loadFlagsEn,
  input  wire logic [7:0]         loadFlagsData,
  input  wire logic               loadMemEn,
  input  wire logic [ADDR_W-1:0]  loadMemAddr,
  input  wire logic [7:0]         loadMemData,
  input  wire logic [ADDR_W-1:0]  peekAddr,
  output logic [7:0]              accOut,
  output logic [7:0]              flagsOut,
  output logic [7:0]              peekData,
  output logic                    busy,
  output logic                    done,
  output logic                    skipNext
);
  import ext_dp_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_DUMMY} dp_state_e;

  localparam int DEPTH = 1 << ADDR_W;

  // ----------------------------------------
  // storage and control state
  // ----------------------------------------
  byte_t              memArr [DEPTH];
  dp_state_e          state_ff;
  far_op_e            op_ff;
  logic [ADDR_W-1:0]  addr_ff;
  logic [2:0]         bit_ff;
  byte_t              operand_ff;
  byte_t              acc_ff;
  byte_t              flags_ff;
  byte_t              peek_ff;
  logic               busy_ff;
  logic               done_ff;
  logic               skip_ff;
  logic               takeReq;
  logic               execNow;

  alu_if aluBus ();

  // ----------------------------------------
  // alu hookup
  // ----------------------------------------
  far_alu u_alu (
    .bus (aluBus.alu)
  );

  // operands come from latched registers so the alu sees a stable cycle
  assign aluBus.op      = op_ff;
  assign aluBus.accIn   = acc_ff;
  assign aluBus.memIn   = operand_ff;
  assign aluBus.bitSel  = bit_ff;
  assign aluBus.flagsIn = flags_ff;

  assign takeReq = start && (state_ff == ST_IDLE);
  assign execNow = (state_ff == ST_EXEC);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // two cycles per instruction, a third dummy slot when skipping
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE:  if (start) state_ff <= ST_FETCH;
        ST_FETCH: state_ff <= ST_EXEC;
        ST_EXEC:  state_ff <= aluBus.skip ? ST_DUMMY : ST_IDLE;
        ST_DUMMY: state_ff <= ST_IDLE;
        default:  state_ff <= ST_IDLE;
      endcase
    end
  end

  // request latch: full address, no bank in the path
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      op_ff   <= far_move_to_acc_op;
      addr_ff <= '0;
      bit_ff  <= 3'h0;
    end else if (takeReq) begin
      op_ff   <= opcode;
      addr_ff <= memAddr;
      bit_ff  <= bitSel;
    end
  end

  // operand read in the fetch slot
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      operand_ff <= 8'h00;
    end else if (state_ff == ST_FETCH) begin
      operand_ff <= memArr[addr_ff];
    end
  end

  // ----------------------------------------
  // architectural state
  // ----------------------------------------
  // accumulator: instruction result, else idle preload
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_ff <= `ACC_RST;
    end else if (execNow) begin
      if (aluBus.toAcc) acc_ff <= aluBus.res;
    end else if (loadAccEn && state_ff == ST_IDLE) begin
      acc_ff <= loadAccData;
    end
  end

  // flags move on the same edge as the value they describe
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_ff <= `FLAGS_RST;
    end else if (execNow) begin
      flags_ff <= aluBus.flagsOut;
    end else if (loadFlagsEn && state_ff == ST_IDLE) begin
      flags_ff <= loadFlagsData;
    end
  end

  // data memory: write-back in the exec slot, preload when idle
  always_ff @(posedge core_clk) begin
    if (execNow && aluBus.toMem) begin
      memArr[addr_ff] <= aluBus.res;
    end else if (loadMemEn && state_ff == ST_IDLE) begin
      memArr[loadMemAddr] <= loadMemData;
    end
  end

  // observation port, one cycle latency
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      peek_ff <= 8'h00;
    end else begin
      peek_ff <= memArr[peekAddr];
    end
  end

  // ----------------------------------------
  // completion and skip report
  // ----------------------------------------
  // done pulses at the end of the last slot; skip rides with it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      done_ff <= 1'b0;
      skip_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      done_ff <= (execNow && !aluBus.skip) || (state_ff == ST_DUMMY);
      skip_ff <= (state_ff == ST_DUMMY);
      busy_ff <= takeReq || (state_ff == ST_FETCH) ||
                 (execNow && aluBus.skip);
    end
  end

  assign accOut   = acc_ff;
  assign flagsOut = flags_ff;
  assign peekData = peek_ff;
  assign busy     = busy_ff;
  assign done     = done_ff;
  assign skipNext = skip_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_exec(far_op_e o);
    execNow && op_ff == o;
  endsequence

  sequence s_issue;
    takeReq ##1 state_ff == ST_FETCH ##1 execNow;
  endsequence

  property p_move_mem;
    s_exec(far_move_op) |=> memArr[addr_ff] == $past(acc_ff) && $stable(flags_ff);
  endproperty
  a_move_mem: assert property (p_move_mem) else $error("move to memory wrong");

  property p_or_acc;
    s_exec(far_or_to_acc_op) |=> acc_ff == ($past(acc_ff) | $past(operand_ff)) &&
      flags_ff[`F_Z] == (acc_ff == 8'h00) && flags_ff[`F_C] == $past(flags_ff[`F_C]);
  endproperty
  a_or_acc: assert property (p_or_acc) else $error("or to acc wrong");

  property p_rlc;
    s_exec(far_rotate_left_thru_carry_op) |=> flags_ff[`F_C] == $past(operand_ff[7]) &&
      memArr[addr_ff] == {$past(operand_ff[6:0]), $past(flags_ff[`F_C])};
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left carry wrong");

  property p_rrca;
    s_exec(far_rotate_right_thru_carry_to_acc_op) |=>
      acc_ff == {$past(flags_ff[`F_C]), $past(operand_ff[7:1])} &&
      memArr[addr_ff] == $past(operand_ff) && flags_ff[`F_C] == $past(operand_ff[0]);
  endproperty
  a_rrca: assert property (p_rrca) else $error("rotate right carry acc wrong");

  property p_sub_carry;
    s_exec(far_subtract_op) |=> flags_ff[`F_C] == ($past(acc_ff) >= $past(operand_ff)) &&
      acc_ff == 8'($past(acc_ff) - $past(operand_ff));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

  property p_sbc_mem;
    s_exec(far_subtract_borrow_to_mem_op) |=> memArr[addr_ff] ==
      8'($past(acc_ff) - $past(operand_ff) - {7'h00, !$past(flags_ff[`F_C])});
  endproperty
  a_sbc_mem: assert property (p_sbc_mem) else $error("subtract borrow wrong");

  property p_skip_len;
    s_issue ##0 aluBus.skip |=> !done_ff ##1 done_ff && skipNext;
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("skip timing wrong");

  property p_noskip_len;
    s_issue ##0 !aluBus.skip |=> done_ff && !skipNext && state_ff == ST_IDLE;
  endproperty
  a_noskip_len: assert property (p_noskip_len) else $error("plain timing wrong");

  property p_dec_skip;
    s_exec(far_dec_skip_zero_op) |=> memArr[addr_ff] == 8'($past(operand_ff) - 8'h01) &&
      (state_ff == ST_DUMMY) == (memArr[addr_ff] == 8'h00) && $stable(flags_ff);
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("decrement skip wrong");

  property p_set_ones;
    s_exec(far_set_ones_op) |=> memArr[addr_ff] == `ALL_ONES && $stable(flags_ff);
  endproperty
  a_set_ones: assert property (p_set_ones) else $error("byte set wrong");

  property p_bit_skip;
    s_exec(far_skip_bit_nonzero_op) |=>
      (state_ff == ST_DUMMY) == $past(operand_ff[bit_ff]);
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit test skip wrong");

  property p_swap;
    s_exec(far_nibble_exchange_op) |=>
      memArr[addr_ff] == {$past(operand_ff[3:0]), $past(operand_ff[7:4])} &&
      $stable(flags_ff);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");

  property p_rot_left;
    s_exec(far_rotate_left_op) |=>
      memArr[addr_ff] == {$past(operand_ff[6:0]), $past(operand_ff[7])} && $stable(flags_ff);
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");

  property p_rot_right;
    s_exec(far_rotate_right_op) |=>
      memArr[addr_ff] == {$past(operand_ff[0]), $past(operand_ff[7:1])} && $stable(flags_ff);
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("rotate right wrong");

  property p_sub_mem;
    s_exec(far_subtract_to_mem_op) |=> memArr[addr_ff] ==
      8'($past(acc_ff) - $past(operand_ff)) && acc_ff == $past(acc_ff);
  endproperty
  a_sub_mem: assert property (p_sub_mem) else $error("subtract to memory wrong");

  property p_inc_acc;
    s_exec(far_inc_skip_zero_to_acc_op) |=> acc_ff == 8'($past(operand_ff) + 8'h01) &&
      memArr[addr_ff] == $past(operand_ff) && $stable(flags_ff) &&
      (state_ff == ST_DUMMY) == (acc_ff == 8'h00);
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("increment skip acc wrong");

  property p_set_bit;
    s_exec(far_set_bit_op) |=> memArr[addr_ff] ==
      ($past(operand_ff) | (`ONE_BYTE << bit_ff)) && $stable(flags_ff);
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set wrong");

  property p_test_byte;
    s_exec(far_skip_nonzero_op) |=> memArr[addr_ff] == $past(operand_ff) &&
      (state_ff == ST_DUMMY) == ($past(operand_ff) != 8'h00);
  endproperty
  a_test_byte: assert property (p_test_byte) else $error("byte test skip wrong");
endmodule

// *** dv/tb.sv ***
// self-checking bench for the far instruction datapath
// assumes ext_dp_pkg, alu_if, far_alu and the datapath are compiled first
`timescale 1ns/10ps
`include "ext_dp_defines.svh"
module tb;
  import ext_dp_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic       core_clk;
  logic       reset_n;
  logic       start;
  far_op_e    opcode;
  logic [8:0] memAddr;
  logic [2:0] bitSel;
  logic       loadAccEn;
  logic [7:0] loadAccData;
  logic       loadFlagsEn;
  logic [7:0] loadFlagsData;
  logic       loadMemEn;
  logic [8:0] loadMemAddr;
  logic [7:0] loadMemData;
  logic [8:0] peekAddr;
  logic [7:0] accOut;
  logic [7:0] flagsOut;
  logic [7:0] peekData;
  logic       busy;
  logic       done;
  logic       skipNext;
  int         fails;
  int         checks;

  extended_instruction_datapath #(.ADDR_W(9)) extended_instruction_datapath_i (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .start         (start),
    .opcode        (opcode),
    .memAddr       (memAddr),
    .bitSel        (bitSel),
    .loadAccEn     (loadAccEn),
    .loadAccData   (loadAccData),
    .loadFlagsEn   (loadFlagsEn),
    .loadFlagsData (loadFlagsData),
    .loadMemEn     (loadMemEn),
    .loadMemAddr   (loadMemAddr),
    .loadMemData   (loadMemData),
    .peekAddr      (peekAddr),
    .accOut        (accOut),
    .flagsOut      (flagsOut),
    .peekData      (peekData),
    .busy          (busy),
    .done          (done),
    .skipNext      (skipNext)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // compare one byte and count it
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // counts and verdict, then stop
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // preload acc, flags and one byte, run one op, judge length, skip, acc, flags, memory
  task automatic apply(input far_op_e op, input logic [8:0] adr, input logic [2:0] bs,
                       input byte_t a, input byte_t m, input byte_t f, input byte_t ea,
                       input byte_t em, input byte_t ef, input int ecyc, input logic esk);
    int n;
    n = 0;
    @(posedge core_clk);
    loadAccEn <= 1'b1;
    loadAccData <= a;
    loadFlagsEn <= 1'b1;
    loadFlagsData <= f;
    loadMemEn <= 1'b1;
    loadMemAddr <= adr;
    loadMemData <= m;
    @(posedge core_clk);
    loadAccEn <= 1'b0;
    loadFlagsEn <= 1'b0;
    loadMemEn <= 1'b0;
    start <= 1'b1;
    opcode <= op;
    memAddr <= adr;
    bitSel <= bs;
    @(posedge core_clk);
    start <= 1'b0;
    #1;
    check("busy", {7'h00, busy}, 8'h01); // in flight after the take
    while (n < 6 && done !== 1'b1) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("cycles", 8'(n), 8'(ecyc)); // length of the op
    check("busy end", {7'h00, busy}, 8'h00); // free again with done
    check("skip", {7'h00, skipNext}, {7'h00, esk}); // skip outcome
    check("acc", accOut, ea); // accumulator result
    check("flags", flagsOut, ef); // status byte
    @(posedge core_clk);
    peekAddr <= adr;
    repeat (2) @(posedge core_clk);
    #1;
    check("mem", peekData, em); // memory byte after the op
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // moves and OR, high and low addresses with no bank
  task automatic t_move_or();
    apply(far_move_op, 9'h1F3, 3'h0, 8'h5A, 8'h00, 8'h3F, 8'h5A, 8'h5A, 8'h3F, 2, 1'b0);
    apply(far_move_to_acc_op, 9'h004, 3'h0, 8'h00, 8'hC3, 8'h00, 8'hC3, 8'hC3, 8'h00, 2, 1'b0);
    apply(far_or_to_acc_op, 9'h0A0, 3'h0, 8'h50, 8'h0A, 8'h3F, 8'h5A, 8'h0A, 8'h3B, 2, 1'b0);
    apply(far_or_to_mem_op, 9'h10F, 3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 2, 1'b0);
    apply(far_or_to_mem_op, 9'h111, 3'h0, 8'h81, 8'h18, 8'h04, 8'h81, 8'h99, 8'h00, 2, 1'b0);
    $display("test move_or done");
  endtask

  // all eight rotates, both carry values, both end bits
  task automatic t_rotate();
    byte_t m;
    byte_t r;
    byte_t f;
    logic  nc;
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 4; k++) begin
        m = k[1] ? 8'h69 : 8'h96;
        f = 8'h3E | {7'h00, k[0]};
        if (i[2] == 1'b0) begin
          r = i[1] ? {m[6:0], k[0]} : {m[6:0], m[7]};
        end else begin
          r = i[1] ? {k[0], m[7:1]} : {m[0], m[7:1]};
        end
        nc = i[1] ? (i[2] ? m[0] : m[7]) : k[0];
        apply(far_op_e'(int'(far_rotate_left_op) + i), 9'h0C0 + 9'(i), 3'h0, 8'hE7, m, f,
              i[0] ? r : 8'hE7, i[0] ? m : r, {f[7:1], nc}, 2, 1'b0);
      end
    end
    $display("test rotate done");
  endtask

  // four subtract variants over sign, overflow and zero cases
  task automatic t_subtract();
    byte_t    av[4] = '{8'h10, 8'h80, 8'h22, 8'h23};
    byte_t    mv[4] = '{8'h20, 8'h01, 8'h22, 8'h22};
    byte_t    fv[4] = '{8'h01, 8'h00, 8'h21, 8'h00};
    logic     brw;
    logic [8:0] r9;
    logic [4:0] lo;
    logic     ov;
    byte_t    ef;
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 4; k++) begin
        brw = i[1] ? 1'b0 : ~fv[k][`F_C];
        r9 = {1'b0, av[k]} - {1'b0, mv[k]} - {8'h00, brw};
        lo = {1'b0, av[k][3:0]} - {1'b0, mv[k][3:0]} - {4'h0, brw};
        ov = (av[k][7] != mv[k][7]) && (r9[7] != av[k][7]);
        ef = fv[k];
        ef[`F_C] = ~r9[8];
        ef[`F_AC] = ~lo[4];
        ef[`F_Z] = (r9[7:0] == 8'h00);
        ef[`F_OV] = ov;
        ef[`F_SC] = r9[7] ^ ov;
        ef[`F_CZ] = i[1] ? ef[`F_Z] : (ef[`F_Z] & fv[k][`F_CZ]);
        apply(far_op_e'(int'(far_subtract_borrow_op) + i), 9'h1A0, 3'h0, av[k], mv[k], fv[k],
              i[0] ? av[k] : r9[7:0], i[0] ? r9[7:0] : mv[k], ef, 2, 1'b0);
      end
    end
    $display("test subtract done");
  endtask

  // decrement and increment skips, memory and accumulator forms
  task automatic t_count_skip();
    byte_t m;
    byte_t r;
    logic  sk;
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 2; k++) begin
        m = i[1] ? (k[0] ? 8'h7F : 8'hFF) : (k[0] ? 8'h05 : 8'h01);
        r = i[1] ? m + 8'h01 : m - 8'h01;
        sk = (r == 8'h00);
        apply(far_op_e'(int'(far_dec_skip_zero_op) + i), 9'h0FF, 3'h0, 8'h33, m, 8'h2A,
              i[0] ? r : 8'h33, i[0] ? m : r, 8'h2A, sk ? 3 : 2, sk);
      end
    end
    $display("test count_skip done");
  endtask

  // set, bit set, bit test, byte test and nibble exchange
  task automatic t_bits();
    apply(far_set_ones_op, 9'h155, 3'h0, 8'h11, 8'h00, 8'h15, 8'h11, 8'hFF, 8'h15, 2, 1'b0);
    for (int b = 0; b < 8; b++) begin
      apply(far_set_bit_op, 9'h020, 3'(b), 8'h11, 8'h24, 8'h3F, 8'h11,
            8'h24 | (8'h01 << b), 8'h3F, 2, 1'b0);
      apply(far_skip_bit_nonzero_op, 9'h1FF, 3'(b), 8'h11, 8'h5A, 8'h00, 8'h11, 8'h5A, 8'h00,
            (8'h5A >> b) & 1 ? 3 : 2, 1'(8'h5A >> b));
    end
    apply(far_skip_nonzero_op, 9'h001, 3'h0, 8'h11, 8'h00, 8'h3F, 8'h11, 8'h00, 8'h3F, 2, 1'b0);
    apply(far_skip_nonzero_op, 9'h002, 3'h0, 8'h11, 8'h40, 8'h3F, 8'h11, 8'h40, 8'h3F, 3, 1'b1);
    apply(far_nibble_exchange_op, 9'h133, 3'h0, 8'h11, 8'hA5, 8'h3F, 8'h11, 8'h5A, 8'h3F, 2, 1'b0);
    $display("test bits done");
  endtask

  // ----------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // inputs at time zero, reset for three cycles, then every scenario
  initial begin
    fails = 0;
    checks = 0;
    reset_n = 1'b0;
    start = 1'b0;
    opcode = far_move_op;
    memAddr = 9'h000;
    bitSel = 3'h0;
    loadAccEn = 1'b0;
    loadAccData = 8'h00;
    loadFlagsEn = 1'b0;
    loadFlagsData = 8'h00;
    loadMemEn = 1'b0;
    loadMemAddr = 9'h000;
    loadMemData = 8'h00;
    peekAddr = 9'h000;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    check("acc after reset", accOut, 8'h00);
    check("flags after reset", flagsOut, 8'h00);
    check("done after reset", {7'h00, done}, 8'h00);
    t_move_or();
    t_rotate();
    t_subtract();
    t_count_skip();
    t_bits();
    end_sim();
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (6000) @(posedge core_clk);
    fails++;
    end_sim();
  end
endmodule
